// *** src/mmd_decoder.sv ***
// module: 8-K memory map decoder with option map switching
`timescale 1ns/10ps
// --------------------------------------------------------------
// --------------------------------------------------------------
module mmd_decoder (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // cpu bus
  input wire mmd_pkg::mmd_req_s req_i,
  input wire logic [7:0] per_rdata_i,
  input wire logic [7:0] mem_rdata_i,
  // decoded selects and read data
  output mmd_pkg::mmd_sel_s sel_o,
  output logic [7:0] rdata_o,
  output logic opt_sel_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    mmd_pkg::mmd_sel_s sel;
    logic [7:0] rdata;
    logic opt_sel;
  } mmd_state_s;

  mmd_state_s st_r;
  mmd_state_s st_nxt;

  function automatic logic in_rng(input logic [12:0] a,
                                  input logic [12:0] lo,
                                  input logic [12:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  logic [12:0] a;
  logic is_misc;
  logic is_low;
  assign a = req_i.addr;
  assign is_misc = (a == mmd_pkg::MISC_ADDR);
  assign is_low = in_rng(a, mmd_pkg::IO_LO, mmd_pkg::OPT_HI);

  // written select bit, sampled by the checks below
  logic wr_sel_bit;
  assign wr_sel_bit = req_i.wdata[mmd_pkg::OPT_SEL_BIT];

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sel.rd = req_i.rd;
    st_nxt.sel.wr = req_i.wr;
    st_nxt.sel.reg_idx = 6'h00;
    st_nxt.sel.ram_idx = 8'h00;
    st_nxt.sel.rom_idx = 13'h0000;
    st_nxt.sel.stack_hit = 1'b0;
    st_nxt.sel.region = mmd_pkg::MMD_RG_NONE;
    st_nxt.rdata = mmd_pkg::UNIMP_RD;
    if (is_low && st_r.opt_sel) begin
      st_nxt.sel.region = mmd_pkg::MMD_RG_OPT;
      st_nxt.sel.reg_idx = a[5:0];
      st_nxt.rdata = per_rdata_i;
    end else if (in_rng(a, mmd_pkg::IO_LO, mmd_pkg::IO_HI)) begin
      st_nxt.sel.region = mmd_pkg::MMD_RG_MAIN;
      st_nxt.sel.reg_idx = a[5:0];
      if (is_misc) begin
        // only the select bit exists; others read zero
        st_nxt.rdata = mmd_pkg::RSVD_RD;
        st_nxt.rdata[mmd_pkg::OPT_SEL_BIT] = st_r.opt_sel;
      end else begin
        st_nxt.rdata = per_rdata_i;
      end
    end else if (in_rng(a, mmd_pkg::RAM_LO, mmd_pkg::RAM_HI)) begin
      st_nxt.sel.region = mmd_pkg::MMD_RG_RAM;
      st_nxt.sel.ram_idx = 8'(a[7:0] - mmd_pkg::RAM_LO[7:0]);
      st_nxt.sel.stack_hit =
        in_rng(a, mmd_pkg::STK_LO, mmd_pkg::STK_HI);
      st_nxt.rdata = mem_rdata_i;
    end else if (in_rng(a, mmd_pkg::ROM_LO, mmd_pkg::ROM_HI)) begin
      st_nxt.sel.region = mmd_pkg::MMD_RG_ROM;
      st_nxt.sel.rom_idx = 13'(a - mmd_pkg::ROM_LO);
      st_nxt.rdata = mem_rdata_i;
    end else if (in_rng(a, mmd_pkg::TROM_LO, mmd_pkg::TROM_HI)) begin
      st_nxt.sel.region = mmd_pkg::MMD_RG_TROM;
      st_nxt.sel.rom_idx = 13'(a - mmd_pkg::TROM_LO);
      st_nxt.rdata = mem_rdata_i;
    end else if (in_rng(a, mmd_pkg::VEC_LO, mmd_pkg::VEC_HI)) begin
      st_nxt.sel.region = mmd_pkg::MMD_RG_VEC;
      st_nxt.sel.rom_idx = 13'(a - mmd_pkg::VEC_LO);
      st_nxt.rdata = mem_rdata_i;
    end
    if (!req_i.rd) begin
      st_nxt.rdata = mmd_pkg::ZERO_BYTE;
    end
    // select bit written in main map; other misc bits dropped
    if (req_i.wr && is_misc) begin
      st_nxt.opt_sel = req_i.wdata[mmd_pkg::OPT_SEL_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.opt_sel <= mmd_pkg::OPT_SEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sel_o = st_r.sel;
  assign rdata_o = st_r.rdata;
  assign opt_sel_o = st_r.opt_sel;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_opt_low_hit: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (st_r.opt_sel && a <= 13'h000f) |=>
      sel_o.region == mmd_pkg::MMD_RG_OPT)
    else $error("low access missed option map");
  a_main_low_hit: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && !st_r.opt_sel && a <= 13'h000f) |=>
      sel_o.region == mmd_pkg::MMD_RG_MAIN)
    else $error("low access missed main map");
  a_io_upper: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (a >= 13'h0010 && a <= 13'h003f) |=>
      sel_o.region == mmd_pkg::MMD_RG_MAIN)
    else $error("io window misdecoded");
  a_ram_range: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (a >= 13'h0050 && a <= 13'h00ff) |=>
      (sel_o.region == mmd_pkg::MMD_RG_RAM &&
       sel_o.ram_idx == 8'($past(a) - 13'h0050)))
    else $error("ram misdecoded");
  a_stack_span: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    sel_o.stack_hit == (sel_o.region == mmd_pkg::MMD_RG_RAM &&
                        sel_o.ram_idx >= 8'h70))
    else $error("stack flag wrong");
  a_rom_range: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (a >= 13'h0700 && a <= 13'h1eff) |=>
      sel_o.region == mmd_pkg::MMD_RG_ROM)
    else $error("user rom misdecoded");
  a_vec_range: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (a >= 13'h1ff0) |=> sel_o.region == mmd_pkg::MMD_RG_VEC)
    else $error("vectors misdecoded");
  a_gap_reads: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (req_i.rd && a >= 13'h0040 && a <= 13'h004f) |=>
      (rdata_o == 8'h00 && sel_o.region == mmd_pkg::MMD_RG_NONE))
    else $error("gap read not zero");
  a_misc_rsvd: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (req_i.rd && a == 13'h003e) |=> (rdata_o & 8'hfd) == 8'h00)
    else $error("reserved misc bits nonzero");
  a_sel_write: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (req_i.wr && a == 13'h003e) |=>
      opt_sel_o == $past(wr_sel_bit))
    else $error("select bit not written");
  a_sel_hold: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    !(req_i.wr && a == 13'h003e) |=> $stable(opt_sel_o))
    else $error("select bit changed by itself");

  // ------------------------------------------------------------
  // reset checks
  // ------------------------------------------------------------
  a_rst_outputs: assert property (@(posedge ref_clk_i)
    (!reset_n_i) [*2] |-> (sel_o == '0 && rdata_o == 8'h00))
    else $error("outputs not cleared in reset");

  a_rst_clear: assert property (@(posedge ref_clk_i)
    (!reset_n_i) [*2] |-> !opt_sel_o)
    else $error("select bit not cleared in reset");

  // ------------------------------------------------------------
  // region and offset checks
  // ------------------------------------------------------------
  a_reg_index: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a <= 13'h003f) |=> sel_o.reg_idx == 6'($past(a)))
    else $error("register index wrong");

  a_hole_none: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a >= 13'h0100 && a <= 13'h06ff) |=>
      (sel_o.region == mmd_pkg::MMD_RG_NONE && rdata_o == 8'h00))
    else $error("unmapped hole decoded");

  a_trom_range: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a >= 13'h1f00 && a <= 13'h1fef) |=>
      sel_o.region == mmd_pkg::MMD_RG_TROM)
    else $error("test rom misdecoded");

  a_rom_offset: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a >= 13'h0700 && a <= 13'h1eff) |=>
      sel_o.rom_idx == 13'($past(a) - 13'h0700))
    else $error("user rom offset wrong");

  a_trom_offset: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a >= 13'h1f00 && a <= 13'h1fef) |=>
      sel_o.rom_idx == 13'($past(a) - 13'h1f00))
    else $error("test rom offset wrong");

  a_vec_offset: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a >= 13'h1ff0) |=>
      sel_o.rom_idx == 13'($past(a) - 13'h1ff0))
    else $error("vector offset wrong");

  a_rom_idle: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a < 13'h0700) |=>
      sel_o.rom_idx == 13'h0000)
    else $error("rom offset outside rom");

  a_ram_idle: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && (a < 13'h0050 || a > 13'h00ff)) |=>
      (sel_o.ram_idx == 8'h00 && !sel_o.stack_hit))
    else $error("ram select outside ram");

  a_stack_top: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && a >= 13'h00c0 && a <= 13'h00ff) |=>
      sel_o.stack_hit)
    else $error("stack area missed");

  // ------------------------------------------------------------
  // read data and strobe copy checks
  // ------------------------------------------------------------
  a_idle_rdata: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && !req_i.rd) |=> rdata_o == 8'h00)
    else $error("read data without a read");

  a_opt_rdata: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && req_i.rd && st_r.opt_sel && a <= 13'h000f) |=>
      rdata_o == $past(per_rdata_i))
    else $error("option map read data wrong");

  a_ram_rdata: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && req_i.rd && a >= 13'h0050 && a <= 13'h00ff) |=>
      rdata_o == $past(mem_rdata_i))
    else $error("ram read data wrong");

  a_rom_rdata: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && req_i.rd && a >= 13'h0700) |=>
      rdata_o == $past(mem_rdata_i))
    else $error("rom read data wrong");

  a_main_rdata: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && req_i.rd && a <= 13'h003f && a != 13'h003e &&
     (a >= 13'h0010 || !st_r.opt_sel)) |=>
      rdata_o == $past(per_rdata_i))
    else $error("main map read data wrong");

  a_rw_copy: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    reset_n_i |=>
      (sel_o.rd == $past(req_i.rd) && sel_o.wr == $past(req_i.wr)))
    else $error("strobe copies wrong");

  // ------------------------------------------------------------
  // select bit checks
  // ------------------------------------------------------------
  a_misc_sel_rd: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    (reset_n_i && req_i.rd && a == 13'h003e) |=>
      rdata_o[1] == $past(opt_sel_o))
    else $error("select bit read back wrong");

  // every misc bit but the select bit reads as a forced zero
  for (genvar gb = 0; gb < 8; gb++) begin : g_misc_bit
    if (gb != mmd_pkg::OPT_SEL_BIT) begin : g_forced
      a_misc_forced: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (reset_n_i && req_i.rd && a == 13'h003e) |=> !rdata_o[gb])
        else $error("forced zero misc bit reads one");
    end
  end
endmodule : mmd_decoder

// *** src/mmd_pkg.sv ***
// package: memory map constants and types for the address decoder
package mmd_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // map boundaries
  localparam logic [12:0] IO_LO = 13'h0000;
  localparam logic [12:0] IO_HI = 13'h003f;
  localparam logic [12:0] OPT_HI = 13'h000f;
  localparam logic [12:0] RAM_LO = 13'h0050;
  localparam logic [12:0] RAM_HI = 13'h00ff;
  localparam logic [12:0] STK_LO = 13'h00c0;
  localparam logic [12:0] STK_HI = 13'h00ff;
  localparam logic [12:0] ROM_LO = 13'h0700;
  localparam logic [12:0] ROM_HI = 13'h1eff;
  localparam logic [12:0] TROM_LO = 13'h1f00;
  localparam logic [12:0] TROM_HI = 13'h1fef;
  localparam logic [12:0] VEC_LO = 13'h1ff0;
  localparam logic [12:0] VEC_HI = 13'h1fff;
  localparam int RAM_BYTES = 176;
  localparam int ROM_BYTES = 6144;
  localparam int VEC_BYTES = 16;
  // miscellaneous register and select bit
  localparam logic [12:0] MISC_ADDR = 13'h003e;
  localparam int OPT_SEL_BIT = 1;
  localparam logic OPT_SEL_RST = 1'b0;
  // value driven for unimplemented bits
  localparam logic [7:0] UNIMP_RD = 8'h00;
  localparam logic [7:0] RSVD_RD = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    MMD_RG_NONE = 3'b000,
    MMD_RG_MAIN = 3'b001,
    MMD_RG_OPT = 3'b010,
    MMD_RG_RAM = 3'b011,
    MMD_RG_ROM = 3'b100,
    MMD_RG_TROM = 3'b101,
    MMD_RG_VEC = 3'b110
  } mmd_region_e;

  typedef struct packed {
    logic [12:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mmd_req_s;

  typedef struct packed {
    mmd_region_e region;
    logic [5:0] reg_idx;
    logic [7:0] ram_idx;
    logic [12:0] rom_idx;
    logic stack_hit;
    logic rd;
    logic wr;
  } mmd_sel_s;
endpackage : mmd_pkg

// *** tb/mmd_far_model.sv ***
// far side model: peripheral and memory read data by address
`timescale 1ns/10ps
module mmd_far_model (
  // request address
  input wire logic [12:0] addr_i,
  // returned read data
  output logic [7:0] per_rdata_o,
  output logic [7:0] mem_rdata_o
);
  assign per_rdata_o = addr_i[7:0] ^ 8'h5a;
  assign mem_rdata_o = ~addr_i[7:0] ^ {3'h0, addr_i[12:8]};
endmodule : mmd_far_model

// *** tb/tb_memory_map_decoder.sv ***
// testbench for the memory map decoder
`timescale 1ns/10ps
module tb_memory_map_decoder;
  typedef struct packed {
    logic [7:0] rgn;
    logic [7:0] rdata;
    logic [7:0] ram_idx;
    logic [5:0] reg_idx;
    logic [12:0] rom_idx;
    logic stk;
    logic opt;
    logic rd;
    logic wr;
    int cyc;
  } mmd_exp_s;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  mmd_pkg::mmd_req_s req_i = '0;
  logic [7:0] per_rdata, mem_rdata, rdata_o;
  mmd_pkg::mmd_sel_s sel_o;
  logic opt_sel_o, opt;
  int failures = 0, num_checks = 0, cyc = 0;
  mmd_exp_s q[$];
  mmd_exp_s e;
  logic [12:0] tbl[18] = '{13'h0, 13'hf, 13'h10, 13'h3f, 13'h40, 13'h4f,
    13'h50, 13'hbf, 13'hc0, 13'hff, 13'h100, 13'h6ff, 13'h700, 13'h1eff,
    13'h1f00, 13'h1fef, 13'h1ff0, 13'h1fff};
  always #5 ref_clk_i = ~ref_clk_i;
  mmd_far_model far (.addr_i(req_i.addr), .per_rdata_o(per_rdata),
    .mem_rdata_o(mem_rdata));
  mmd_decoder DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .req_i(req_i), .per_rdata_i(per_rdata), .mem_rdata_i(mem_rdata),
    .sel_o(sel_o), .rdata_o(rdata_o), .opt_sel_o(opt_sel_o));
  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    num_checks++;
    if (x !== g) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic access(logic [12:0] a, logic r, logic [7:0] d);
    mmd_exp_s x;
    @(posedge ref_clk_i);
    req_i <= '{addr: a, rd: r, wr: !r, wdata: d};
    x = '0;
    x.rgn = (a <= 13'hf) ? (opt ? 8'h2 : 8'h1) : (a <= 13'h3f) ? 8'h1 :
      (a >= 13'h50 && a <= 13'hff) ? 8'h3 : (a < 13'h700) ? 8'h0 :
      (a <= 13'h1eff) ? 8'h4 : (a <= 13'h1fef) ? 8'h5 : 8'h6;
    if (r && x.rgn != 8'h0)
      x.rdata = (x.rgn <= 8'h2) ? a[7:0] ^ 8'h5a : ~a[7:0] ^ {3'h0, a[12:8]};
    // misc register: only the select bit, the rest read zero
    if (r && a == 13'h3e) x.rdata = {6'h0, opt, 1'b0};
    x.ram_idx = (x.rgn == 8'h3) ? a[7:0] - 8'h50 : 8'h0;
    x.reg_idx = (x.rgn == 8'h1 || x.rgn == 8'h2) ? a[5:0] : 6'h0;
    x.rom_idx = (x.rgn == 8'h4) ? a - 13'h700 :
      (x.rgn == 8'h5) ? a - 13'h1f00 : (x.rgn == 8'h6) ? a - 13'h1ff0 : 13'h0;
    x.stk = (a >= 13'hc0 && a <= 13'hff);
    if (!r && a == 13'h3e) opt = d[1];
    x.opt = opt;
    x.rd = r;
    x.wr = !r;
    x.cyc = cyc;
    q.push_back(x);
  endtask : access
  task automatic idle(int n);
    @(posedge ref_clk_i);
    req_i <= '0;
    repeat (n) @(posedge ref_clk_i);
  endtask : idle
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    #1;
    if (reset_n_i && q.size() > 0 && q[0].cyc == cyc - 2) begin
      e = q.pop_front();
      chk("region", e.rgn, {5'h0, sel_o.region});
      chk("rdata", e.rdata, rdata_o);
      if (e.rgn == 8'h3) chk("ram_idx", e.ram_idx, sel_o.ram_idx);
      chk("stack", {7'h0, e.stk}, {7'h0, sel_o.stack_hit});
      chk("opt_sel", {7'h0, e.opt}, {7'h0, opt_sel_o});
      chk("rd", {7'h0, e.rd}, {7'h0, sel_o.rd});
      chk("wr", {7'h0, e.wr}, {7'h0, sel_o.wr});
      chk("reg_idx", 8'(e.reg_idx), 8'(sel_o.reg_idx));
      chk("rom_lo", e.rom_idx[7:0], sel_o.rom_idx[7:0]);
      chk("rom_hi", 8'(e.rom_idx >> 8), 8'(sel_o.rom_idx >> 8));
    end
  end
  task automatic conclude();
    chk("pending", 8'h00, 8'(q.size()));
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    opt = 1'b0;
    void'($urandom(32'hebd5));
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    chk("opt_rst", 8'h0, {7'h0, opt_sel_o});
    for (int p = 0; p < 2; p++) begin
      foreach (tbl[i]) access(tbl[i], 1'b1, 8'h0);
      foreach (tbl[i]) access(tbl[i], 1'b0, 8'($urandom));
      access(13'h3e, 1'b0, 8'h02);
      for (int i = 0; i < 16; i++) access(13'(i), 1'b1, 8'h0);
    end
    access(13'h3e, 1'b0, 8'h00);
    for (int i = 0; i < 300; i++)
      access(($urandom % 2) ? 13'($urandom % 256) : 13'($urandom),
        1'($urandom), 8'($urandom) & 8'h02);
    access(13'h3e, 1'b0, 8'h02);
    idle(3);
    reset_n_i <= 1'b0;
    opt = 1'b0;
    idle(2);
    chk("opt_mid", 8'h0, {7'h0, opt_sel_o});
    chk("rgn_mid", 8'h0, {5'h0, sel_o.region});
    reset_n_i <= 1'b1;
    access(13'h05, 1'b1, 8'h0);
    idle(3);
    conclude();
  end
endmodule : tb_memory_map_decoder
